// ---- lpo_regs.sv ----
// Line and path overhead alarm, interrupt and error-count register bank.
// Assumes APB master on CLK_IN; overhead inputs are from other clock-domain logic
// and pass two flip-flops; event inputs are level-per-cycle, one event per cycle.
// Interrupt output is a registered OR of the enabled status flags.
`timescale 1ns/1ps
`default_nettype none
module lpo_regs (
	input  wire logic                 CLK_IN,
	input  wire logic                 RST_N_IN,
	input  wire logic                 PSEL_IN,
	input  wire logic                 PENABLE_IN,
	input  wire logic                 PWRITE_IN,
	input  wire logic [11:0]          PADDR_IN,
	input  wire logic [31:0]          PWDATA_IN,
	output logic [31:0]               PRDATA_OUT,
	output logic                      PREADY_OUT,
	output logic                      PSLVERR_OUT,
	input  wire lpo_pkg::lpo_line_ev_s LINE_EV_IN,
	input  wire lpo_pkg::lpo_path_ev_s PATH_EV_IN,
	input  wire logic                 TX_REMOTE_FAIL_PIN_IN,
	input  wire logic [7:0]           TX_K2_IN,
	input  wire logic [7:0]           TX_B2_IN,
	output logic [7:0]                TX_K2_OUT,
	output logic [7:0]                TX_B2_OUT,
	output logic                      LOAD_METERS_OUT,
	output logic                      IRQ_OUT
);
	lpo_pkg::lpo_line_ev_s line_s1;
	lpo_pkg::lpo_line_ev_s line_s2;
	lpo_pkg::lpo_path_ev_s path_s1;
	lpo_pkg::lpo_path_ev_s path_s2;
	logic       pin_s1;
	logic       pin_s2;
	logic       line_rf_prev;
	logic       line_ais_prev;
	logic       ptr_prev;
	logic       path_alarm_ind_state_prev;
	logic       path_yellow_state_prev;
	logic [3:0] line_flag;
	logic [3:0] line_en;
	logic [7:0] path_flag;
	logic [7:0] path_en;
	logic       tx_remote_fail_insert;
	logic       tx_line_parity_corrupt;
	logic [7:0] label_cand;
	logic [7:0] label;
	logic [lpo_pkg::CNT_W-1:0] acc_parity;
	logic [lpo_pkg::CNT_W-1:0] acc_block;
	logic [lpo_pkg::CNT_W-1:0] line_parity_error_count;
	logic [lpo_pkg::CNT_W-1:0] line_block_error_count;
	logic [1:0] poll_cnt;
	logic       poll_busy;
	logic       access;
	logic       wr;
	logic       rd;
	logic [9:0] idx;
	logic       mapped;
	logic       poll_wr;
	logic       poll_fire;
	logic [7:0] rd_byte;
	logic [3:0] line_set;
	logic [7:0] path_set;
	logic       sel_line_irq;
	logic       sel_path_irq;
	logic       sel_load;
	logic       line_irq_any;
	logic       path_irq_any;

	// Two-stage synchronisers; only the second stage is read
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			line_s1 <= '0;
			line_s2 <= '0;
		end else begin
			line_s1 <= LINE_EV_IN;
			line_s2 <= line_s1;
		end
	end

	// The label rides with its frame mark, so both see the same two stages
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			path_s1 <= '0;
			path_s2 <= '0;
		end else begin
			path_s1 <= PATH_EV_IN;
			path_s2 <= path_s1;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
		end else begin
			pin_s1 <= TX_REMOTE_FAIL_PIN_IN;
			pin_s2 <= pin_s1;
		end
	end

	assign access  = PSEL_IN && PENABLE_IN;
	assign wr      = access && PWRITE_IN;
	assign rd      = access && !PWRITE_IN;
	assign idx     = PADDR_IN[11:lpo_pkg::ADDR_LSB];
	// Decodes shared by the read-clear and load-meters logic
	assign sel_line_irq = idx == {2'h0, lpo_pkg::IDX_LINE_IRQ};
	assign sel_path_irq = idx == {2'h0, lpo_pkg::IDX_PATH_IRQ};
	assign sel_load     = idx == {2'h0, lpo_pkg::IDX_LOAD_METERS};
	assign poll_wr = wr && (idx[9:8] == 2'h0) && ((idx[7:0] >= lpo_pkg::IDX_LBE_LOW
		&& idx[7:0] <= lpo_pkg::IDX_LFE_HIGH)
		|| idx[7:0] == lpo_pkg::IDX_LOAD_METERS);

	// A flag raised in the setup cycle is reported now, since the access edge clears it
	always_comb begin
		mapped = 1'b1;
		rd_byte = 8'h00;
		if (idx[9:8] != 2'h0) begin
			mapped = 1'b0;
		end else begin
			case (idx[7:0])
				lpo_pkg::IDX_LINE_IRQ:    rd_byte = {line_en, line_flag | line_set};
				lpo_pkg::IDX_LBE_LOW:     rd_byte = line_parity_error_count[7:0];
				lpo_pkg::IDX_LBE_MID:     rd_byte = line_parity_error_count[15:8];
				lpo_pkg::IDX_LBE_HIGH:    rd_byte = {4'h0, line_parity_error_count[19:16]};
				lpo_pkg::IDX_LFE_LOW:     rd_byte = line_block_error_count[7:0];
				lpo_pkg::IDX_LFE_MID:     rd_byte = line_block_error_count[15:8];
				lpo_pkg::IDX_LFE_HIGH:    rd_byte = {4'h0, line_block_error_count[19:16]};
				lpo_pkg::IDX_TX_CTRL:     rd_byte = {7'h00, tx_remote_fail_insert};
				lpo_pkg::IDX_TX_DIAG:     rd_byte = {7'h00, tx_line_parity_corrupt};
				lpo_pkg::IDX_PATH_STAT:   rd_byte = {2'h0, path_s2.ptr_loss, 1'b0,
					path_s2.alarm_ind, path_s2.yellow, 2'h0};
				lpo_pkg::IDX_PATH_IRQ:    rd_byte = path_flag | path_set;
				lpo_pkg::IDX_PATH_EN:     rd_byte = path_en;
				lpo_pkg::IDX_PATH_LABEL:  rd_byte = label;
				lpo_pkg::IDX_LOAD_METERS: rd_byte = 8'h00;
				default:                  mapped = 1'b0;
			endcase
		end
	end

	// Zero-wait APB: answer in the access cycle itself
	// Writes and read-clears act only at the access edge, with PREADY high
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			PRDATA_OUT  <= 32'h0000_0000;
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
			PSLVERR_OUT <= 1'b0;
			if (PSEL_IN && !PENABLE_IN) begin
				PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : {24'h000000, rd_byte};
				PSLVERR_OUT <= !mapped;
			end
		end
	end

	// Control registers; reserved bits are not stored and read back as zero, except path_en, which keeps all eight written bits
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			line_en <= 4'h0;
		end else if (wr && PREADY_OUT && sel_line_irq) begin
			line_en <= PWDATA_IN[7:4];
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			path_en <= 8'h00;
		end else if (wr && PREADY_OUT && idx == {2'h0, lpo_pkg::IDX_PATH_EN}) begin
			path_en <= PWDATA_IN[7:0];
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			tx_remote_fail_insert <= 1'b0;
		end else if (wr && PREADY_OUT && idx == {2'h0, lpo_pkg::IDX_TX_CTRL}) begin
			tx_remote_fail_insert <= PWDATA_IN[0];
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			tx_line_parity_corrupt <= 1'b0;
		end else if (wr && PREADY_OUT && idx == {2'h0, lpo_pkg::IDX_TX_DIAG}) begin
			tx_line_parity_corrupt <= PWDATA_IN[0];
		end
	end

	// Alarm state history for change detection
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			line_rf_prev  <= 1'b0;
			line_ais_prev <= 1'b0;
		end else begin
			line_rf_prev  <= line_s2.remote_fail;
			line_ais_prev <= line_s2.alarm_ind;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ptr_prev  <= 1'b0;
			path_alarm_ind_state_prev <= 1'b0;
			path_yellow_state_prev <= 1'b0;
		end else begin
			ptr_prev  <= path_s2.ptr_loss;
			path_alarm_ind_state_prev <= path_s2.alarm_ind;
			path_yellow_state_prev <= path_s2.yellow;
		end
	end

	// Signal label must repeat in two consecutive frames before it is taken
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			label_cand <= 8'h00;
			label      <= 8'h00;
		end else if (path_s2.frame) begin
			label_cand <= path_s2.label;
			if (path_s2.label == label_cand) begin
				label <= label_cand;
			end
		end
	end

	always_comb begin
		line_set[0] = line_s2.remote_fail != line_rf_prev;
		line_set[1] = line_s2.alarm_ind != line_ais_prev;
		line_set[2] = line_s2.parity_err;
		line_set[3] = line_s2.block_err;
		path_set = 8'h00;
		path_set[lpo_pkg::BIT_LABEL] = path_s2.frame && path_s2.label == label_cand
			&& label_cand != label;
		path_set[lpo_pkg::BIT_PTR_LOSS] = path_s2.ptr_loss != ptr_prev;
		path_set[lpo_pkg::BIT_AIS] = path_s2.alarm_ind != path_alarm_ind_state_prev;
		path_set[lpo_pkg::BIT_YELLOW] = path_s2.yellow != path_yellow_state_prev;
		path_set[lpo_pkg::BIT_PARITY] = path_s2.parity_err;
		path_set[lpo_pkg::BIT_BLOCK] = path_s2.block_err;
	end

	// Read clears; a new event in the same cycle wins over the clear
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			line_flag <= 4'h0;
		end else if (rd && PREADY_OUT && sel_line_irq) begin
			line_flag <= line_set;
		end else begin
			line_flag <= line_flag | line_set;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			path_flag <= 8'h00;
		end else if (rd && PREADY_OUT && sel_path_irq) begin
			path_flag <= path_set;
		end else begin
			path_flag <= path_flag | path_set;
		end
	end

	// A flag whose enable is low stays readable but raises no interrupt
	always_comb begin
		line_irq_any = |(line_flag & line_en);
		path_irq_any = |(path_flag & path_en & lpo_pkg::PATH_IRQ_MASK);
	end

	// Interrupt follows the flags one cycle behind them
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= line_irq_any || path_irq_any;
		end
	end

	// Poll is deferred a fixed short time, well inside the 1 us allowance
	assign poll_fire = poll_busy && poll_cnt == 2'(lpo_pkg::POLL_DELAY - 1);

	// Other counter blocks take this pulse as their own poll
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			LOAD_METERS_OUT <= 1'b0;
		end else begin
			LOAD_METERS_OUT <= wr && PREADY_OUT && sel_load;
		end
	end

	// A second poll write while one is pending restarts the wait
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			poll_busy <= 1'b0;
			poll_cnt  <= 2'h0;
		end else if (poll_wr && PREADY_OUT) begin
			poll_busy <= 1'b1;
			poll_cnt  <= 2'h0;
		end else if (poll_fire) begin
			poll_busy <= 1'b0;
		end else if (poll_busy) begin
			poll_cnt <= poll_cnt + 2'h1;
		end
	end

	// Snapshot and restart; an event in the poll cycle starts the new count
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			acc_parity              <= '0;
			line_parity_error_count <= '0;
		end else if (poll_fire) begin
			line_parity_error_count <= acc_parity;
			acc_parity              <= {19'h00000, line_s2.parity_err};
		end else if (line_s2.parity_err && acc_parity != '1) begin
			acc_parity <= acc_parity + 20'h00001;
		end
	end

	// Counts stick at all ones rather than wrap, so a flood never reads small
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			acc_block              <= '0;
			line_block_error_count <= '0;
		end else if (poll_fire) begin
			line_block_error_count <= acc_block;
			acc_block              <= {19'h00000, line_s2.block_err};
		end else if (line_s2.block_err && acc_block != '1) begin
			acc_block <= acc_block + 20'h00001;
		end
	end

	// Remote-fail code replaces the low three K2 bits; the rest pass through
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			TX_K2_OUT <= 8'h00;
		end else if (tx_remote_fail_insert || pin_s2) begin
			TX_K2_OUT <= {TX_K2_IN[7:3], lpo_pkg::REMOTE_FAIL_CODE};
		end else begin
			TX_K2_OUT <= TX_K2_IN;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			TX_B2_OUT <= 8'h00;
		end else begin
			TX_B2_OUT <= tx_line_parity_corrupt ? ~TX_B2_IN : TX_B2_IN;
		end
	end
endmodule
`default_nettype wire

// ---- lpo_pkg.sv ----
// Package for the line/path overhead alarm register bank.
// Assumes an APB master with 32-bit data and one register per aligned word.
package lpo_pkg;
	// Printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] IDX_LINE_IRQ   = 8'h19;
	localparam logic [7:0] IDX_LBE_LOW    = 8'h1a;
	localparam logic [7:0] IDX_LBE_MID    = 8'h1b;
	localparam logic [7:0] IDX_LBE_HIGH   = 8'h1c;
	localparam logic [7:0] IDX_LFE_LOW    = 8'h1d;
	localparam logic [7:0] IDX_LFE_MID    = 8'h1e;
	localparam logic [7:0] IDX_LFE_HIGH   = 8'h1f;
	localparam logic [7:0] IDX_TX_CTRL    = 8'h20;
	localparam logic [7:0] IDX_TX_DIAG    = 8'h21;
	localparam logic [7:0] IDX_PATH_STAT  = 8'h30;
	localparam logic [7:0] IDX_PATH_IRQ   = 8'h31;
	localparam logic [7:0] IDX_PATH_EN    = 8'h33;
	localparam logic [7:0] IDX_PATH_LABEL = 8'h37;
	localparam logic [7:0] IDX_LOAD_METERS = 8'h38;
	localparam int         ADDR_LSB       = 2;

	// Line interrupt register fields
	localparam int LINE_FLAG_LSB = 0;
	localparam int LINE_EN_LSB   = 4;
	// Path register field positions
	localparam int BIT_LABEL     = 7;
	localparam int BIT_PTR_LOSS  = 5;
	localparam int BIT_AIS       = 3;
	localparam int BIT_YELLOW    = 2;
	localparam int BIT_PARITY    = 1;
	localparam int BIT_BLOCK     = 0;
	localparam logic [7:0] PATH_IRQ_MASK  = 8'haf;
	localparam logic [7:0] PATH_STAT_RW   = 8'h81;

	localparam int         CNT_W          = 20;
	localparam logic [2:0] REMOTE_FAIL_CODE = 3'h6;

	// Poll latency: up to about 1 us, rounded down in cycles
	localparam int CLK_MHZ      = 100;
	localparam int POLL_TIME_NS = 1000;
	localparam int POLL_CYCLES  = POLL_TIME_NS * CLK_MHZ / 1000;
	localparam int POLL_DELAY   = 2;

	typedef struct packed {
		logic remote_fail;
		logic alarm_ind;
		logic parity_err;
		logic block_err;
	} lpo_line_ev_s;

	typedef struct packed {
		logic       ptr_loss;
		logic       alarm_ind;
		logic       yellow;
		logic       parity_err;
		logic       block_err;
		logic       frame;
		logic [7:0] label;
	} lpo_path_ev_s;
endpackage

// ---- lpo_props.sv ----
// Checker for the overhead alarm register bank, bound to lpo_regs.
// Sees only top-level ports; everything runs on CLK_IN.
`timescale 1ns/1ps
`default_nettype none
module lpo_props (
	input wire logic        CLK_IN,
	input wire logic        RST_N_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic        PREADY_OUT,
	input wire logic        TX_REMOTE_FAIL_PIN_IN,
	input wire logic [7:0]  TX_K2_IN,
	input wire logic [7:0]  TX_B2_IN,
	input wire logic [7:0]  TX_K2_OUT,
	input wire logic [7:0]  TX_B2_OUT,
	input wire logic        LOAD_METERS_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	wire logic       rd_done = PREADY_OUT && !PWRITE_IN;
	wire logic [9:0] idx     = PADDR_IN[11:2];
	AST_K2_PASS: assert property ($past(RST_N_IN) |-> TX_K2_OUT[7:3] == $past(TX_K2_IN[7:3]))
		else $error("K2 upper bits not passed through");
	AST_K2_CODE: assert property ($past(RST_N_IN) && TX_K2_OUT[2:0] != $past(TX_K2_IN[2:0]) |-> TX_K2_OUT[2:0] == 3'h6)
		else $error("K2 low bits altered without the remote-fail code");
	AST_K2_PIN: assert property (TX_REMOTE_FAIL_PIN_IN [*4] |=> TX_K2_OUT[2:0] == 3'h6)
		else $error("Fail pin did not insert the remote-fail code");
	AST_B2_INV: assert property ($past(RST_N_IN) |-> TX_B2_OUT == $past(TX_B2_IN) || TX_B2_OUT == ~$past(TX_B2_IN))
		else $error("B2 neither passed nor inverted");
	AST_LOAD: assert property (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && idx == 10'h38 |=> LOAD_METERS_OUT)
		else $error("Load-meters write gave no pulse");
	AST_LOAD_CAUSE: assert property (LOAD_METERS_OUT |-> $past(PSEL_IN && PENABLE_IN && PWRITE_IN && idx == 10'h38))
		else $error("Load-meters pulse without its write");
	AST_NIBBLE: assert property (rd_done && (idx == 10'h1c || idx == 10'h1f) |-> PRDATA_OUT[7:4] == 4'h0)
		else $error("Counter upper byte wider than a nibble");
	AST_PATH_STAT: assert property (rd_done && idx == 10'h30 |-> (PRDATA_OUT[7:0] & 8'hd3) == 8'h00)
		else $error("Path status shows bits outside the alarm states");
endmodule
bind lpo_regs lpo_props lpo_props_inst (.CLK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
	.PADDR_IN, .PRDATA_OUT, .PREADY_OUT, .TX_REMOTE_FAIL_PIN_IN, .TX_K2_IN, .TX_B2_IN,
	.TX_K2_OUT, .TX_B2_OUT, .LOAD_METERS_OUT);
`default_nettype wire

// ---- lpo_partner.sv ----
// Receive overhead processing model: alarm state levels and error pulses.
// Bits 17:14 line events, 13:0 path events, as the package structs order them.
`timescale 1ns/1ps
`default_nettype none
module lpo_partner (
	input  wire logic          clk_in,
	output lpo_pkg::lpo_line_ev_s line_ev_out,
	output lpo_pkg::lpo_path_ev_s path_ev_out
);
	logic [17:0] ev_q = 18'h0;
	assign line_ev_out = ev_q[17:14];
	assign path_ev_out = ev_q[13:0];
	// States toggle and stay; errors and frame marks last one cycle
	task automatic hit(input int b, input logic [7:0] lab);
		@(posedge clk_in);
		ev_q[b] <= ~ev_q[b];
		ev_q[7:0] <= lab;
		if (b inside {15, 14, 10, 9, 8}) begin
			@(posedge clk_in);
			ev_q[b] <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for lpo_regs over APB with the overhead model.
// Assumes zero-wait APB and three-cycle input latency to the flags.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pin = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, load, irq;
	logic [7:0]  k2_in = 8'h01, b2_in = 8'h5a, k2_out, b2_out;
	lpo_pkg::lpo_line_ev_s line_ev;
	lpo_pkg::lpo_path_ev_s path_ev;
	logic [31:0] r;
	logic        e;
	int          error_cnt = 0, checked = 0;
	lpo_regs lpo_regs_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LINE_EV_IN(line_ev), .PATH_EV_IN(path_ev),
		.TX_REMOTE_FAIL_PIN_IN(pin), .TX_K2_IN(k2_in), .TX_B2_IN(b2_in), .TX_K2_OUT(k2_out),
		.TX_B2_OUT(b2_out), .LOAD_METERS_OUT(load), .IRQ_OUT(irq));
	lpo_partner lpo_partner_inst (.clk_in(clk), .line_ev_out(line_ev), .path_ev_out(path_ev));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {2'b0, ix, 2'b0};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) error_cnt++;
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rdc(input logic [7:0] ix, input logic [7:0] exp);
		apb(0, ix, 8'h0);
		chk(r, {24'h0, exp});
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		wrap_up;
	end
	initial begin
		wait_n(3);
		rst_n <= 1;
		apb(0, 8'h19, 8'h0);
		chk(r & 32'hf0, 32'h0);
		for (int en = 0; en < 2; en++) begin
			apb(1, 8'h19, en ? 8'hf0 : 8'h00);
			for (int i = 0; i < 4; i++) begin
				lpo_partner_inst.hit(17 - i, 8'h0);
				wait_n(6);
				chk(irq, en);
				rdc(8'h19, (en ? 8'hf0 : 8'h00) | (8'h01 << i));
				wait_n(3);
				chk(irq, 0);
			end
		end
		apb(1, 8'h1a, 8'h0);
		repeat (259) lpo_partner_inst.hit(15, 8'h0);
		repeat (2) lpo_partner_inst.hit(14, 8'h0);
		wait_n(6);
		apb(1, 8'h1f, 8'h0);
		wait_n(4);
		rdc(8'h1a, 8'h03);
		rdc(8'h1b, 8'h01);
		rdc(8'h1c, 8'h00);
		rdc(8'h1d, 8'h02);
		apb(1, 8'h38, 8'h0);
		wait_n(4);
		rdc(8'h1a, 8'h00);
		rdc(8'h1d, 8'h00);
		rdc(8'h19, 8'hfc);
		apb(1, 8'h20, 8'h01);
		wait_n(2);
		chk(k2_out, 8'h06);
		apb(1, 8'h20, 8'h00);
		pin <= 1;
		wait_n(4);
		chk(k2_out, 8'h06);
		pin <= 0;
		apb(1, 8'h21, 8'h01);
		wait_n(2);
		chk(b2_out, 8'ha5);
		chk(k2_out, 8'h01);
		apb(1, 8'h21, 8'h00);
		apb(1, 8'h33, 8'h04);
		for (int j = 0; j < 3; j++) lpo_partner_inst.hit(11 + ((j * 2) % 3), 8'h0);
		wait_n(6);
		chk(irq, 1);
		rdc(8'h30, 8'h2c);
		rdc(8'h31, 8'h2c);
		wait_n(3);
		chk(irq, 0);
		lpo_partner_inst.hit(10, 8'h0);
		lpo_partner_inst.hit(9, 8'h0);
		wait_n(6);
		chk(irq, 0);
		rdc(8'h31, 8'h03);
		lpo_partner_inst.hit(8, 8'h13);
		wait_n(6);
		rdc(8'h31, 8'h00);
		lpo_partner_inst.hit(8, 8'h13);
		wait_n(6);
		rdc(8'h31, 8'h80);
		rdc(8'h37, 8'h13);
		apb(0, 8'h3f, 8'h0);
		chk({e, r[30:0]}, 32'h80000000);
		wrap_up;
	end
endmodule
`default_nettype wire
